// ==== hdl/pdeg_pkg.sv ====
// Package: register map, field positions and reset values of the port D/E pin block
package pdeg_pkg;

  localparam int PDEG_D_WIDTH = 8;
  localparam int PDEG_E_WIDTH = 3;
  localparam int PDEG_ADDR_WIDTH = 8;

  // Register byte offsets on the APB
  localparam logic [7:0] PDEG_OFS_D_LEVELS = 8'h00;
  localparam logic [7:0] PDEG_OFS_D_LATCH = 8'h04;
  localparam logic [7:0] PDEG_OFS_D_DIR = 8'h08;
  localparam logic [7:0] PDEG_OFS_E_LEVELS = 8'h0C;
  localparam logic [7:0] PDEG_OFS_E_LATCH = 8'h10;
  localparam logic [7:0] PDEG_OFS_E_DIR = 8'h14;
  localparam logic [7:0] PDEG_OFS_ANALOG_CFG = 8'h18;
  localparam logic [7:0] PDEG_OFS_PERIPH_CTRL = 8'h1C;

  // Field positions in the bank E levels register
  localparam int PDEG_POS_D_PULLUP = 7;
  localparam int PDEG_POS_E_PULLUP = 6;
  // Field positions in the analog configuration register (bank E pins 0..2)
  localparam int PDEG_POS_ANALOG_E0 = 5;
  // Field positions in the peripheral control register
  localparam int PDEG_POS_PAR_OWN_D = 0;
  localparam int PDEG_POS_PAR_OWN_E = 1;
  localparam int PDEG_POS_REMAP_D = 2;

  // Reset values
  localparam logic [7:0] PDEG_RST_D_LATCH = 8'h00;
  localparam logic [7:0] PDEG_RST_D_DIR = 8'hFF;
  localparam logic [2:0] PDEG_RST_E_LATCH = 3'h0;
  localparam logic [2:0] PDEG_RST_E_DIR = 3'h7;
  localparam logic [7:0] PDEG_RST_ANALOG_CFG = 8'h00;
  localparam logic [2:0] PDEG_RST_PERIPH_CTRL = 3'h0;
  localparam logic PDEG_RST_PULLUP = 1'b0;

  // Pin group carried as one bundle
  typedef struct packed {
    logic [PDEG_D_WIDTH-1:0] dout;
    logic [PDEG_D_WIDTH-1:0] doe;
    logic [PDEG_D_WIDTH-1:0] dpull;
  } pdeg_bank_d_t;

  typedef struct packed {
    logic [PDEG_E_WIDTH-1:0] dout;
    logic [PDEG_E_WIDTH-1:0] doe;
    logic [PDEG_E_WIDTH-1:0] dpull;
  } pdeg_bank_e_t;

  typedef enum logic [1:0] {
    PDEG_IDLE,
    PDEG_ACCESS
  } pdeg_apb_state_t;

endpackage

// ==== hdl/pdeg_port_d_e_gpio.sv ====
// Port D/E general-purpose pin block with APB register access
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1: Three-bit bank E exists only when the large-package parameter is set.
// R2: Bank E has exactly three pins, each independently input or output.
// R3: Bank E pin in analog mode reads as zero.
// R4: Direction bit one makes a bank E pin an input, driver off.
// R5: Direction bit zero makes a bank E pin drive its latch bit.
// R6: Bank E direction bits control drivers even in analog mode.
// R7: Software keeps analog bank E pins set as inputs.
// R8: After reset all bank E pins are analog inputs.
// R9: Latch registers read back stored latch value, not pin level.
// R10: Bit six of bank E levels enables all bank E pull-ups.
// R11: A pull-up is off whenever its pin is an output.
// R12: Reset leaves all pull-ups disabled.
// R13: Bank D has levels, latch and direction registers, bit n for pin n.
// R14: Bank D registers are absent on the small package.
// R15: Bank D direction one reads pin level; zero drives latch bit.
// R16: Parallel port owns pins 3..7: direction selects parallel data in or out.
// R17: Bank D pins 3..7 are remap pins 20..24, direction sets way.
// R18: Where function is don't-care, the function overrides direction.
// R19: Bit seven of bank E levels enables bank D pull-ups by direction.
// R20: Bank E levels bits 5..3 read zero; bits 2..0 are input levels.
// R21: Setting an analog select bit makes that bank E pin digital.
module pdeg_port_d_e_gpio
  import pdeg_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PDEG_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PDEG_D_WIDTH-1:0] pin_bank_d_in,
  output logic [PDEG_D_WIDTH-1:0] pin_bank_d_out,
  output logic [PDEG_D_WIDTH-1:0] pin_bank_d_oe,
  output logic [PDEG_D_WIDTH-1:0] pin_bank_d_pullup,
  input wire logic [PDEG_E_WIDTH-1:0] pin_bank_e_in,
  output logic [PDEG_E_WIDTH-1:0] pin_bank_e_out,
  output logic [PDEG_E_WIDTH-1:0] pin_bank_e_oe,
  output logic [PDEG_E_WIDTH-1:0] pin_bank_e_pullup,
  input wire logic [4:0] parallel_data_out,
  output logic [4:0] parallel_data_in,
  input wire logic [PDEG_E_WIDTH-1:0] parallel_strobe_out,
  input wire logic [4:0] remap_out,
  output logic [4:0] remap_in,
  output logic [PDEG_E_WIDTH-1:0] bank_e_analog_en
);

  logic [PDEG_D_WIDTH-1:0] d_latch;
  logic [PDEG_D_WIDTH-1:0] d_dir;
  logic [PDEG_E_WIDTH-1:0] e_latch;
  logic [PDEG_E_WIDTH-1:0] e_dir;
  logic [7:0] analog_cfg;
  logic [2:0] periph_ctrl;
  logic bank_d_pullup_enable;
  logic bank_e_pullup_enable;
  logic [PDEG_D_WIDTH-1:0] d_sync1, d_sync2;
  logic [PDEG_E_WIDTH-1:0] e_sync1, e_sync2;
  pdeg_apb_state_t state;
  pdeg_bank_d_t next_bank_d;
  pdeg_bank_e_t next_bank_e;
  logic [PDEG_E_WIDTH-1:0] e_analog;
  logic [PDEG_E_WIDTH-1:0] bank_e_input_bits;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic wr_en;

  // Address decode used by both the write enable and the error check
  function automatic logic pdeg_mapped(input logic [PDEG_ADDR_WIDTH-1:0] a);
    logic d_ok;
    logic e_ok;
    d_ok = LARGE_PACKAGE && (a == PDEG_OFS_D_LEVELS || a == PDEG_OFS_D_LATCH ||
                             a == PDEG_OFS_D_DIR); // R14
    e_ok = LARGE_PACKAGE && (a == PDEG_OFS_E_LEVELS || a == PDEG_OFS_E_LATCH ||
                             a == PDEG_OFS_E_DIR); // R1
    return d_ok || e_ok || a == PDEG_OFS_ANALOG_CFG || a == PDEG_OFS_PERIPH_CTRL;
  endfunction

  // Pin input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_sync1 <= '0;
      d_sync2 <= '0;
      e_sync1 <= '0;
      e_sync2 <= '0;
    end else begin
      d_sync1 <= pin_bank_d_in;
      d_sync2 <= d_sync1;
      e_sync1 <= pin_bank_e_in;
      e_sync2 <= e_sync1;
    end
  end

  // Analog select bit set means digital; reset value makes all analog
  always_comb begin
    for (int i = 0; i < PDEG_E_WIDTH; i++) begin
      e_analog[i] = ~analog_cfg[PDEG_POS_ANALOG_E0 + i]; // R8 R21
    end
    bank_e_input_bits = e_sync2 & ~e_analog; // R3
  end

  assign wr_en = psel && penable && pwrite && (state == PDEG_ACCESS) &&
                 pdeg_mapped(paddr);

  // APB: setup cycle then one access cycle, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PDEG_IDLE;
    end else begin
      case (state)
        PDEG_IDLE: begin
          if (psel && !penable) begin
            state <= PDEG_ACCESS;
          end
        end
        PDEG_ACCESS: begin
          state <= PDEG_IDLE;
        end
        default: begin
          state <= PDEG_IDLE;
        end
      endcase
    end
  end

  // Bank D registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_latch <= PDEG_RST_D_LATCH;
      d_dir <= PDEG_RST_D_DIR;
    end else if (wr_en && LARGE_PACKAGE) begin
      if (paddr == PDEG_OFS_D_LATCH || paddr == PDEG_OFS_D_LEVELS) begin
        d_latch <= pwdata[PDEG_D_WIDTH-1:0]; // R9 R13
      end
      if (paddr == PDEG_OFS_D_DIR) begin
        d_dir <= pwdata[PDEG_D_WIDTH-1:0]; // R13
      end
    end
  end

  // Bank E registers and pull-up enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_latch <= PDEG_RST_E_LATCH;
      e_dir <= PDEG_RST_E_DIR;
      bank_d_pullup_enable <= PDEG_RST_PULLUP; // R12
      bank_e_pullup_enable <= PDEG_RST_PULLUP; // R12
    end else if (wr_en && LARGE_PACKAGE) begin
      if (paddr == PDEG_OFS_E_LATCH) begin
        e_latch <= pwdata[PDEG_E_WIDTH-1:0]; // R9
      end
      if (paddr == PDEG_OFS_E_LEVELS) begin
        e_latch <= pwdata[PDEG_E_WIDTH-1:0];
        bank_d_pullup_enable <= pwdata[PDEG_POS_D_PULLUP]; // R19
        bank_e_pullup_enable <= pwdata[PDEG_POS_E_PULLUP]; // R10
      end
      if (paddr == PDEG_OFS_E_DIR) begin
        e_dir <= pwdata[PDEG_E_WIDTH-1:0]; // R2
      end
    end
  end

  // Analog and peripheral ownership controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_cfg <= PDEG_RST_ANALOG_CFG; // R8
      periph_ctrl <= PDEG_RST_PERIPH_CTRL;
    end else if (wr_en) begin
      if (paddr == PDEG_OFS_ANALOG_CFG) begin
        analog_cfg <= pwdata[7:0]; // R21
      end
      if (paddr == PDEG_OFS_PERIPH_CTRL) begin
        periph_ctrl <= pwdata[2:0];
      end
    end
  end

  // Pin drive, enable and pull-up for both banks
  always_comb begin
    next_bank_d = '0;
    next_bank_e = '0;
    if (LARGE_PACKAGE) begin
      for (int i = 0; i < PDEG_D_WIDTH; i++) begin
        next_bank_d.doe[i] = ~d_dir[i]; // R15
        next_bank_d.dout[i] = d_latch[i]; // R15
        if (i >= 3 && periph_ctrl[PDEG_POS_REMAP_D]) begin
          next_bank_d.dout[i] = remap_out[i-3]; // R17
        end else if (i >= 3 && periph_ctrl[PDEG_POS_PAR_OWN_D]) begin
          next_bank_d.dout[i] = parallel_data_out[i-3]; // R16
        end
        next_bank_d.dpull[i] = bank_d_pullup_enable & d_dir[i]; // R11 R19
      end
      for (int j = 0; j < PDEG_E_WIDTH; j++) begin
        next_bank_e.doe[j] = ~e_dir[j]; // R4 R5 R6
        next_bank_e.dout[j] = periph_ctrl[PDEG_POS_PAR_OWN_E] ?
                              parallel_strobe_out[j] : e_latch[j]; // R5
        next_bank_e.dpull[j] = bank_e_pullup_enable & e_dir[j]; // R10 R11
      end
      // Select line is output-only when the parallel port owns it
      if (periph_ctrl[PDEG_POS_PAR_OWN_E]) begin
        next_bank_e.doe[2] = 1'b1; // R18
        next_bank_e.dpull[2] = 1'b0; // R11
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_bank_d_out <= '0;
      pin_bank_d_oe <= '0;
      pin_bank_d_pullup <= '0;
      pin_bank_e_out <= '0;
      pin_bank_e_oe <= '0;
      pin_bank_e_pullup <= '0;
      bank_e_analog_en <= '1;
    end else begin
      pin_bank_d_out <= next_bank_d.dout;
      pin_bank_d_oe <= next_bank_d.doe;
      pin_bank_d_pullup <= next_bank_d.dpull;
      pin_bank_e_out <= next_bank_e.dout;
      pin_bank_e_oe <= next_bank_e.doe;
      pin_bank_e_pullup <= next_bank_e.dpull;
      bank_e_analog_en <= e_analog;
    end
  end

  // Incoming data to parallel port and remap inputs, input direction only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_data_in <= '0;
      remap_in <= '0;
    end else begin
      parallel_data_in <= d_sync2[7:3] & d_dir[7:3] & {5{periph_ctrl[PDEG_POS_PAR_OWN_D]}}; // R16
      remap_in <= d_sync2[7:3] & d_dir[7:3] & {5{periph_ctrl[PDEG_POS_REMAP_D]}}; // R17
    end
  end

  // Read data mux
  always_comb begin
    next_prdata = '0;
    next_slverr = ~pdeg_mapped(paddr);
    if (LARGE_PACKAGE) begin
      case (paddr)
        PDEG_OFS_D_LEVELS: next_prdata[7:0] = d_sync2; // R15
        PDEG_OFS_D_LATCH: next_prdata[7:0] = d_latch; // R9
        PDEG_OFS_D_DIR: next_prdata[7:0] = d_dir;
        PDEG_OFS_E_LEVELS: begin
          next_prdata[PDEG_POS_D_PULLUP] = bank_d_pullup_enable;
          next_prdata[PDEG_POS_E_PULLUP] = bank_e_pullup_enable;
          next_prdata[2:0] = bank_e_input_bits; // R20
        end
        PDEG_OFS_E_LATCH: next_prdata[2:0] = e_latch; // R9
        PDEG_OFS_E_DIR: next_prdata[2:0] = e_dir;
        default: next_prdata = '0;
      endcase
    end
    if (paddr == PDEG_OFS_ANALOG_CFG) begin
      next_prdata[7:0] = analog_cfg;
    end
    if (paddr == PDEG_OFS_PERIPH_CTRL) begin
      next_prdata[2:0] = periph_ctrl;
    end
  end

  // Answer registered so bus outputs come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable && state == PDEG_IDLE) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_slverr;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== test/pdeg_board.sv ====
// Board model: drives the pin inputs, follows the block where it drives
`timescale 1ns/100ps
`default_nettype none
module pdeg_board
  import pdeg_pkg::*;
(
  input wire logic [7:0] d_out,
  input wire logic [7:0] d_oe,
  input wire logic [7:0] board_d,
  output logic [7:0] d_in,
  input wire logic [2:0] e_out,
  input wire logic [2:0] e_oe,
  input wire logic [2:0] board_e,
  output logic [2:0] e_in
);
  // A driven pin reads back what the block drives, else the board level
  assign d_in = (d_out & d_oe) | (board_d & ~d_oe);
  assign e_in = (e_out & e_oe) | (board_e & ~e_oe);
endmodule
`default_nettype wire

// ==== test/pdeg_port_d_e_gpio_assertions.sv ====
// Concurrent checks on the port D/E pin block ports
`timescale 1ns/100ps
`default_nettype none
module pdeg_port_d_e_gpio_chk
  import pdeg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PDEG_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PDEG_D_WIDTH-1:0] pin_bank_d_oe,
  input wire logic [PDEG_D_WIDTH-1:0] pin_bank_d_pullup,
  input wire logic [PDEG_E_WIDTH-1:0] pin_bank_e_oe,
  input wire logic [PDEG_E_WIDTH-1:0] pin_bank_e_pullup,
  input wire logic [PDEG_E_WIDTH-1:0] bank_e_analog_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready && pwrite && !pslverr;
  property p_ready; psel && !penable |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_rst;
    $rose(presetn) |-> bank_e_analog_en == 3'h7 && {pin_bank_d_pullup, pin_bank_e_pullup} == 11'h0;
  endproperty
  property p_e_oe;
    acc && paddr == PDEG_OFS_E_DIR |-> ##2 pin_bank_e_oe == ~$past(pwdata[2:0], 2);
  endproperty
  property p_d_oe;
    acc && paddr == PDEG_OFS_D_DIR |-> ##2 pin_bank_d_oe == ~$past(pwdata[7:0], 2);
  endproperty
  property p_e_pu; (pin_bank_e_pullup & pin_bank_e_oe) == 3'h0; endproperty
  property p_d_pu; (pin_bank_d_pullup & pin_bank_d_oe) == 8'h00; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_e_oe: assert property (p_e_oe) else $error("bank E driver mismatch");
  a_d_oe: assert property (p_d_oe) else $error("bank D driver mismatch");
  a_e_pu: assert property (p_e_pu) else $error("bank E pull-up on output");
  a_d_pu: assert property (p_d_pu) else $error("bank D pull-up on output");
  c_wr: cover property (acc);
  c_rd: cover property (pready && !pwrite);
  c_err: cover property (pslverr);
endmodule
bind pdeg_port_d_e_gpio pdeg_port_d_e_gpio_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .pin_bank_d_oe(pin_bank_d_oe),
  .pin_bank_d_pullup(pin_bank_d_pullup), .pin_bank_e_oe(pin_bank_e_oe),
  .pin_bank_e_pullup(pin_bank_e_pullup), .bank_e_analog_en(bank_e_analog_en));
`default_nettype wire

// ==== test/pdeg_port_d_e_gpio_bench.sv ====
// Self-checking bench for the port D/E pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, x, g) begin n_compared++; if ((g) !== (x)) begin n_errors++; \
  $display("Error %s exp %h got %h", nm, x, g); end end
module pdeg_port_d_e_gpio_bench
  import pdeg_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [7:0] paddr = 8'h00, bd = 8'h3C, d_out, d_oe, d_pu, d_in;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [2:0] be = 3'h2, e_out, e_oe, e_pu, e_in, an;
  logic [4:0] pdo = 5'h13, rmo = 5'h0C, pdi, rmi;
  int n_errors = 0, n_compared = 0;
  always #10 pclk = ~pclk;
  pdeg_port_d_e_gpio i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_bank_d_in(d_in), .pin_bank_d_out(d_out), .pin_bank_d_oe(d_oe),
    .pin_bank_d_pullup(d_pu), .pin_bank_e_in(e_in), .pin_bank_e_out(e_out),
    .pin_bank_e_oe(e_oe), .pin_bank_e_pullup(e_pu), .parallel_data_out(pdo),
    .parallel_data_in(pdi), .parallel_strobe_out(3'h0), .remap_out(rmo), .remap_in(rmi),
    .bank_e_analog_en(an));
  pdeg_board i_board (.d_out(d_out), .d_oe(d_oe), .board_d(bd), .d_in(d_in),
    .e_out(e_out), .e_oe(e_oe), .board_e(be), .e_in(e_in));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Access ends at the edge where pready is sampled high; only the watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, r)
  endtask
  task settle;
    repeat (3) @(negedge pclk);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("analog", 3'h7, an)
    `CHK("pullups", 11'h0, {d_pu, e_pu})
    `CHK("drivers", 11'h0, {d_oe, e_oe})
    chk_rd(PDEG_OFS_D_DIR, 32'hFF, "d_dir");
    chk_rd(PDEG_OFS_E_DIR, 32'h7, "e_dir");
    chk_rd(PDEG_OFS_D_LATCH, 32'h0, "d_latch");
    chk_rd(PDEG_OFS_E_LEVELS, 32'h0, "e_levels");
    $display("reset test done");
    wr(PDEG_OFS_D_LATCH, 32'hA5);
    wr(PDEG_OFS_D_DIR, 32'h0F);
    settle;
    `CHK("d_oe", 8'hF0, d_oe)
    `CHK("d_out", 4'hA, d_out[7:4])
    chk_rd(PDEG_OFS_D_LATCH, 32'hA5, "d_latch");
    chk_rd(PDEG_OFS_D_LEVELS, 32'hAC, "d_levels");
    wr(PDEG_OFS_ANALOG_CFG, 32'h60);
    settle;
    `CHK("analog", 3'h4, an)
    chk_rd(PDEG_OFS_E_LEVELS, 32'h2, "e_levels");
    wr(PDEG_OFS_ANALOG_CFG, 32'hE0);
    wr(PDEG_OFS_E_LATCH, 32'h5);
    wr(PDEG_OFS_E_DIR, 32'h3);
    settle;
    `CHK("e_oe", 3'h4, e_oe)
    `CHK("e_out", 1'b1, e_out[2])
    chk_rd(PDEG_OFS_E_LATCH, 32'h5, "e_latch");
    chk_rd(PDEG_OFS_E_LEVELS, 32'h6, "e_levels");
    wr(PDEG_OFS_E_LEVELS, 32'hC5);
    settle;
    `CHK("pullups", 11'h07B, {d_pu, e_pu})
    chk_rd(PDEG_OFS_E_LEVELS, 32'hC6, "e_levels");
    $display("pin test done");
    for (int m = 0; m < 2; m++) begin
      wr(PDEG_OFS_PERIPH_CTRL, m ? 32'h4 : 32'h1);
      settle;
      `CHK("d_out", m ? 4'h6 : 4'h9, d_out[7:4])
      `CHK("func_in", 1'b1, m ? rmi[0] : pdi[0])
    end
    wr(PDEG_OFS_PERIPH_CTRL, 32'h0);
    $display("function test done");
    apb(1'b1, 8'h20, 32'hFF);
    `CHK("slverr", 1'b1, e)
    chk_rd(8'h20, 32'h0, "unmapped");
    wr(PDEG_OFS_E_LEVELS, 32'h05);
    settle;
    `CHK("pullups", 11'h0, {d_pu, e_pu})
    $display("refusal test done");
    complete_run;
  end
endmodule
`default_nettype wire
